// File: verilog/cml_lock_ctrl.sv
// Function
// - Three signature bytes readable at fixed code addresses identify maker and part.
// - Verify read-out allowed only while lock bits two and three are unprogrammed.
// - Lock bit one blocks table reads from external code fetching internal bytes.
// - Lock bit one latches external access select at reset, ignoring later changes.
// - Lock bit one refuses any further programming of internal code memory.
// - Bits one and two add a block on verify read-out.
// - All three bits additionally forbid execution from external code memory.
// - Only four cumulative lock patterns defined; others treated as strictest.
// - Unlocked verify data still passes through the scrambling table if programmed.
//
// Decided for this implementation: the register addresses and the APB register port.
module cml_lock_ctrl
  import cml_pkg::*;
#(
  parameter logic [7:0] SIG_MAKER = CML_SIG_MAKER_DEF,
  parameter logic [7:0] SIG_PART = CML_SIG_PART_DEF,
  parameter logic [7:0] SIG_EXTRA = CML_SIG_EXTRA_DEF
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Nonvolatile lock bits, stable levels
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic lock_bit_three,
  // External access select pin, high selects internal code
  input wire logic external_access_select,
  // Scrambling table
  input wire logic scramble_programmed,
  input wire logic [7:0] scramble_key,
  // Programmer verify port
  input wire logic verify_req,
  input wire logic [13:0] verify_addr,
  input wire logic [7:0] verify_array_data,
  output logic verify_valid,
  output logic verify_refused,
  output logic [7:0] verify_data,
  // Programmer write port
  input wire logic prog_req,
  output logic prog_grant,
  output logic prog_refused,
  // Core fetch and table read
  input wire logic code_table_read_instruction,
  input wire logic fetch_from_external,
  input wire logic [7:0] table_array_data,
  output logic [7:0] table_data,
  output logic table_refused,
  input wire logic ext_fetch_req,
  output logic ext_fetch_allow,
  output logic internal_code_select,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_raw;
  logic [3:0] pins_sync;
  assign pins_raw = {external_access_select, lock_bit_three, lock_bit_two, lock_bit_one};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      cml_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .din(pins_raw[gi]),
        .dout(pins_sync[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Lock capture after reset
  // ----------------------------------------------------------------
  // Capture waits for the synchroniser to fill; until then stay strict
  logic [1:0] settle_reg;
  logic captured_reg;
  logic [2:0] lock_reg;
  logic sel_latched_reg;
  wire capture_now = !captured_reg && (settle_reg == CML_SETTLE_LAST);

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      settle_reg <= 2'h0;
      captured_reg <= 1'b0;
      lock_reg <= CML_LOCK_STRICT;
      sel_latched_reg <= 1'b0;
    end
    else
    begin
      if (settle_reg != CML_SETTLE_LAST)
        settle_reg <= settle_reg + 2'h1;
      if (capture_now)
      begin
        captured_reg <= 1'b1;
        lock_reg <= pins_sync[2:0];
        sel_latched_reg <= pins_sync[3];
      end
    end
  end

  cml_level_t level;
  cml_restrict_t rst_c;
  cml_decode u_decode (
    .lock_bits(lock_reg),
    .level(level),
    .restrict_o(rst_c)
  );

  // Before capture every verify, programming, external table read and external fetch request is refused
  wire ready_ok = captured_reg;

  // ----------------------------------------------------------------
  // External access select
  // ----------------------------------------------------------------
  wire sel_live = pins_sync[3];
  wire sel_use = rst_c.sel_latch ? sel_latched_reg : sel_live;

  // ----------------------------------------------------------------
  // Verify and signature read
  // ----------------------------------------------------------------
  wire sig_hit_m = verify_addr == CML_SIG_ADDR_MAKER;
  wire sig_hit_p = verify_addr == CML_SIG_ADDR_PART;
  wire sig_hit_e = verify_addr == CML_SIG_ADDR_EXTRA;
  wire sig_hit = sig_hit_m || sig_hit_p || sig_hit_e;
  wire [7:0] sig_byte = sig_hit_m ? SIG_MAKER : (sig_hit_p ? SIG_PART : SIG_EXTRA);
  // Signature stays readable even when the array is locked
  wire verify_ok = ready_ok && (sig_hit || !rst_c.verify_block);
  wire [7:0] scr_byte = scramble_programmed ? (verify_array_data ^ scramble_key) :
                        verify_array_data;
  wire [7:0] verify_next = sig_hit ? sig_byte : scr_byte;

  // ----------------------------------------------------------------
  // Programming and core access
  // ----------------------------------------------------------------
  wire prog_ok = ready_ok && !rst_c.prog_block;
  wire table_block = code_table_read_instruction && fetch_from_external &&
                     (rst_c.table_block || !ready_ok);
  wire exec_ok = ready_ok && !rst_c.exec_block;

  logic [7:0] verify_data_reg;
  logic verify_valid_reg;
  logic verify_refused_reg;
  logic prog_grant_reg;
  logic prog_refused_reg;
  logic [7:0] table_data_reg;
  logic table_refused_reg;
  logic ext_allow_reg;
  logic int_sel_reg;
  logic [CML_VIO_W-1:0] vio_reg;

  // ----------------------------------------------------------------
  // Verify answer
  // ----------------------------------------------------------------
  // Refused reads return all ones so no array byte leaks out
  wire [7:0] verify_data_next = verify_ok ? verify_next : 8'hFF;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      verify_valid_reg <= 1'b0;
      verify_refused_reg <= 1'b0;
    end
    else
    begin
      verify_valid_reg <= verify_req && verify_ok;
      verify_refused_reg <= verify_req && !verify_ok;
    end
  end

  // Data holds between requests
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      verify_data_reg <= 8'h00;
    else if (verify_req)
      verify_data_reg <= verify_data_next;
  end

  // ----------------------------------------------------------------
  // Programming answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prog_grant_reg <= 1'b0;
      prog_refused_reg <= 1'b0;
    end
    else
    begin
      prog_grant_reg <= prog_req && prog_ok;
      prog_refused_reg <= prog_req && !prog_ok;
    end
  end

  // ----------------------------------------------------------------
  // Table read answer
  // ----------------------------------------------------------------
  wire [7:0] table_data_next = table_block ? 8'hFF : table_array_data;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      table_data_reg <= 8'h00;
      table_refused_reg <= 1'b0;
    end
    else
    begin
      table_data_reg <= table_data_next;
      table_refused_reg <= table_block;
    end
  end

  // ----------------------------------------------------------------
  // External fetch and code select
  // ----------------------------------------------------------------
  wire int_sel_next = sel_use && ready_ok;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ext_allow_reg <= 1'b0;
      int_sel_reg <= 1'b0;
    end
    else
    begin
      ext_allow_reg <= ext_fetch_req && exec_ok;
      int_sel_reg <= int_sel_next;
    end
  end

  assign verify_valid = verify_valid_reg;
  assign verify_refused = verify_refused_reg;
  assign verify_data = verify_data_reg;
  assign prog_grant = prog_grant_reg;
  assign prog_refused = prog_refused_reg;
  assign table_data = table_data_reg;
  assign table_refused = table_refused_reg;
  assign ext_fetch_allow = ext_allow_reg;
  assign internal_code_select = int_sel_reg;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_acc = psel && penable;
  wire hit_stat = paddr == CML_OFF_LOCK_STATUS;
  wire hit_vio = paddr == CML_OFF_VIOLATION;
  wire hit_sm = paddr == CML_OFF_SIG_MAKER;
  wire hit_sp = paddr == CML_OFF_SIG_PART;
  wire hit_se = paddr == CML_OFF_SIG_EXTRA;
  wire hit_any = hit_stat || hit_vio || hit_sm || hit_sp || hit_se;
  // Only the violation register takes writes, one to clear
  wire bad_acc = !hit_any || (pwrite && !hit_vio);
  wire vio_clr = apb_acc && pwrite && hit_vio;

  logic [CML_VIO_W-1:0] vio_evt;
  assign vio_evt[CML_VIO_PROG] = prog_req && !prog_ok;
  assign vio_evt[CML_VIO_VERIFY] = verify_req && !verify_ok;
  assign vio_evt[CML_VIO_TABLE] = table_block;
  assign vio_evt[CML_VIO_EXEC] = ext_fetch_req && !exec_ok;
  assign vio_evt[CML_VIO_UNDEF] = rst_c.undefined && captured_reg;

  // Event wins over a clear in the same cycle
  wire [CML_VIO_W-1:0] vio_next = (vio_reg & ~(vio_clr ? pwdata[CML_VIO_W-1:0] :
                                   {CML_VIO_W{1'b0}})) | vio_evt;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      vio_reg <= {CML_VIO_W{1'b0}};
    else
      vio_reg <= vio_next;
  end

  wire [31:0] stat_word = {20'h00000, level, 1'b0, sel_latched_reg, captured_reg, 1'b0,
                           1'b0, lock_reg};
  wire [31:0] rd_mux = hit_stat ? stat_word :
                       hit_vio ? {27'h0000000, vio_reg} :
                       hit_sm ? {24'h000000, SIG_MAKER} :
                       hit_sp ? {24'h000000, SIG_PART} :
                       hit_se ? {24'h000000, SIG_EXTRA} : CML_RESET_WORD;

  logic [31:0] prdata_reg;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prdata_reg <= CML_RESET_WORD;
    else if (psel && !penable && !pwrite)
      prdata_reg <= rd_mux;
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = apb_acc && bad_acc;

endmodule

// File: verilog/cml_pkg.sv
package cml_pkg;

  // ----------------------------------------------------------------
  // Signature locations and values
  // ----------------------------------------------------------------
  localparam logic [13:0] CML_SIG_ADDR_MAKER = 14'h0030;
  localparam logic [13:0] CML_SIG_ADDR_PART = 14'h0031;
  localparam logic [13:0] CML_SIG_ADDR_EXTRA = 14'h0060;
  // Arbitrary neutral identity values
  localparam logic [7:0] CML_SIG_MAKER_DEF = 8'hA5;
  localparam logic [7:0] CML_SIG_PART_DEF = 8'h5A;
  localparam logic [7:0] CML_SIG_EXTRA_DEF = 8'h3C;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CML_OFF_LOCK_STATUS = 12'h000;
  localparam logic [11:0] CML_OFF_VIOLATION = 12'h004;
  localparam logic [11:0] CML_OFF_SIG_MAKER = 12'h008;
  localparam logic [11:0] CML_OFF_SIG_PART = 12'h00C;
  localparam logic [11:0] CML_OFF_SIG_EXTRA = 12'h010;
  localparam logic [31:0] CML_RESET_WORD = 32'h0000_0000;
  // Capture timing, and the strict lock value held until capture
  localparam logic [1:0] CML_SETTLE_LAST = 2'h2;
  localparam logic [2:0] CML_LOCK_STRICT = 3'h7;

  // Violation bit positions
  localparam int CML_VIO_PROG = 0;
  localparam int CML_VIO_VERIFY = 1;
  localparam int CML_VIO_TABLE = 2;
  localparam int CML_VIO_EXEC = 3;
  localparam int CML_VIO_UNDEF = 4;
  localparam int CML_VIO_W = 5;

  // ----------------------------------------------------------------
  // Protection levels
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CML_LVL_OPEN = 4'b0001,
    CML_LVL_ONE = 4'b0010,
    CML_LVL_TWO = 4'b0100,
    CML_LVL_ALL = 4'b1000
  } cml_level_t;

  typedef struct packed {
    logic table_block;
    logic sel_latch;
    logic prog_block;
    logic verify_block;
    logic exec_block;
    logic undefined;
  } cml_restrict_t;

  typedef struct packed {
    logic [13:0] addr;
    logic [7:0] data;
  } cml_code_t;

endpackage

// File: verilog/cml_sync.sv
module cml_sync
  import cml_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Level
  input wire logic din,
  output logic dout
);

  logic meta_reg;
  logic sync_reg;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

// File: verilog/cml_decode.sv
module cml_decode
  import cml_pkg::*;
(
  // Lock bits
  input wire logic [2:0] lock_bits,
  // Result
  output cml_level_t level,
  output cml_restrict_t restrict_o
);

  // Non-cumulative patterns fall to the strictest level, the safe side
  wire any_set = |lock_bits;
  wire pat_one = lock_bits == 3'b001;
  wire pat_two = lock_bits == 3'b011;
  wire pat_open = !any_set;
  wire pat_all = lock_bits == 3'b111;
  wire pat_undef = !(pat_open || pat_one || pat_two || pat_all);

  assign level = pat_open ? CML_LVL_OPEN :
                 pat_one ? CML_LVL_ONE :
                 pat_two ? CML_LVL_TWO : CML_LVL_ALL;

  assign restrict_o.table_block = any_set;
  assign restrict_o.sel_latch = any_set;
  assign restrict_o.prog_block = any_set;
  assign restrict_o.verify_block = pat_two || pat_all || pat_undef;
  assign restrict_o.exec_block = pat_all || pat_undef;
  assign restrict_o.undefined = pat_undef;

endmodule

// File: testbench/cml_lock_ctrl_chk.sv
module cml_lock_ctrl_chk
  import cml_pkg::*;
#(
  parameter logic [7:0] SIG_MAKER = CML_SIG_MAKER_DEF
)
(
  // Clock, reset, locks
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic lock_bit_one,
  input wire logic lock_bit_two,
  input wire logic lock_bit_three,
  // Requests
  input wire logic scramble_programmed,
  input wire logic [7:0] scramble_key,
  input wire logic verify_req,
  input wire logic [13:0] verify_addr,
  input wire logic [7:0] verify_array_data,
  input wire logic prog_req,
  input wire logic code_table_read_instruction,
  input wire logic fetch_from_external,
  input wire logic ext_fetch_req,
  // Answers
  input wire logic verify_valid,
  input wire logic verify_refused,
  input wire logic [7:0] verify_data,
  input wire logic prog_grant,
  input wire logic prog_refused,
  input wire logic [7:0] table_data,
  input wire logic table_refused,
  input wire logic ext_fetch_allow,
  input wire logic internal_code_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] cap_reg;
  logic [2:0] up_reg;
  logic [7:0] vd_reg;
  wire live = up_reg == 3'h7;
  wire sig = verify_addr inside {CML_SIG_ADDR_MAKER, CML_SIG_ADDR_PART, CML_SIG_ADDR_EXTRA};
  // ----
  // Reference locks taken in reset; pin moves later must not matter
  // ----
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      cap_reg <= {lock_bit_three, lock_bit_two, lock_bit_one};
    vd_reg <= verify_array_data ^ (scramble_programmed ? scramble_key : 8'h00);
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      up_reg <= 3'h0;
    else
      up_reg <= live ? up_reg : up_reg + 3'h1;
  end
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  property p_sig;
    live && verify_req && verify_addr == CML_SIG_ADDR_MAKER |=> verify_valid && verify_data == SIG_MAKER;
  endproperty
  a_sig: assert property (p_sig) else $error("signature wrong");
  property p_vok;
    live && verify_req && !sig && cap_reg == 3'h0 |=> verify_valid && verify_data == vd_reg;
  endproperty
  a_vok: assert property (p_vok) else $error("verify data wrong");
  property p_vblk;
    live && verify_req && !sig && cap_reg[2:1] != 2'h0 |=> verify_refused && verify_data == 8'hFF;
  endproperty
  a_vblk: assert property (p_vblk) else $error("verify not blocked");
  property p_idle;
    live && !verify_req |=> !verify_valid && !verify_refused;
  endproperty
  a_idle: assert property (p_idle) else $error("answer without request");
  property p_prog;
    live && prog_req |=> prog_grant == (cap_reg == 3'h0) && prog_refused != prog_grant;
  endproperty
  a_prog: assert property (p_prog) else $error("program gate wrong");
  property p_tbl;
    live && code_table_read_instruction && fetch_from_external && cap_reg != 3'h0
      |=> table_refused && table_data == 8'hFF;
  endproperty
  a_tbl: assert property (p_tbl) else $error("table read leaked");
  property p_exec;
    live && ext_fetch_req |=> ext_fetch_allow == (cap_reg inside {3'h0, 3'h1, 3'h3});
  endproperty
  a_exec: assert property (p_exec) else $error("external fetch gate wrong");
  property p_sel;
    live && cap_reg != 3'h0 |=> $stable(internal_code_select);
  endproperty
  a_sel: assert property (p_sel) else $error("code select moved");
endmodule

bind cml_lock_ctrl cml_lock_ctrl_chk #(.SIG_MAKER(SIG_MAKER)) u_chk (.*);

// File: testbench/cml_prog_model.sv
module cml_prog_model
  import cml_pkg::*;
(
  // Clock and commands
  input wire logic mclk,
  input wire logic [2:0] level,
  input wire logic go,
  input wire logic [13:0] addr,
  // Toward the device
  output logic [2:0] lock_bits,
  output logic verify_req = 1'b0,
  output logic [13:0] verify_addr = 14'h0000,
  output logic prog_req = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Cumulative patterns; code 4 is a deliberate bad one
  assign lock_bits = level == 3'h4 ? 3'h2 : 3'h7 >> (3'h3 - level);
  // Address wanders when idle, so stale values never look valid
  always @(posedge mclk)
  begin
    verify_req <= go;
    prog_req <= go;
    verify_addr <= go ? addr : ~verify_addr;
  end
endmodule

// File: testbench/code_memory_lock_control_test.sv
module code_memory_lock_control_test
  import cml_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [2:0] lvl;
    logic scr;
    logic [7:0] vd;
    logic vv;
    logic pg;
    logic [7:0] tb;
    logic ex;
    logic isel;
    logic [11:0] st;
    logic [4:0] vio;
  } cml_row_t;
  cml_row_t rows [6] = '{'{3'h0, 1'b1, 8'h33, 1'b1, 1'b1, 8'h77, 1'b1, 1'b0, 12'h160, 5'h00},
    '{3'h0, 1'b0, 8'h3C, 1'b1, 1'b1, 8'h77, 1'b1, 1'b0, 12'h160, 5'h00},
    '{3'h1, 1'b1, 8'h33, 1'b1, 1'b0, 8'hFF, 1'b1, 1'b1, 12'h261, 5'h05},
    '{3'h2, 1'b1, 8'hFF, 1'b0, 1'b0, 8'hFF, 1'b1, 1'b1, 12'h463, 5'h07},
    '{3'h3, 1'b1, 8'hFF, 1'b0, 1'b0, 8'hFF, 1'b0, 1'b1, 12'h867, 5'h0F},
    '{3'h4, 1'b1, 8'hFF, 1'b0, 1'b0, 8'hFF, 1'b0, 1'b1, 12'h862, 5'h1F}};
  logic [13:0] sig_a [3] = '{CML_SIG_ADDR_MAKER, CML_SIG_ADDR_PART, CML_SIG_ADDR_EXTRA};
  logic [7:0] sig_v [3] = '{CML_SIG_MAKER_DEF, CML_SIG_PART_DEF, CML_SIG_EXTRA_DEF};
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic external_access_select = 1'b1;
  logic scramble_programmed = 1'b0;
  logic [7:0] scramble_key = 8'h0F;
  logic [7:0] verify_array_data = 8'h3C;
  logic [7:0] table_array_data = 8'h77;
  logic code_table_read_instruction = 1'b0;
  logic fetch_from_external = 1'b0;
  logic ext_fetch_req = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] level = 3'h0;
  logic go = 1'b0;
  logic [13:0] addr = 14'h0100;
  logic [2:0] lock_bits;
  logic verify_req, prog_req, verify_valid, verify_refused, prog_grant, prog_refused;
  logic table_refused, ext_fetch_allow, internal_code_select, pready, pslverr, er;
  logic [13:0] verify_addr;
  logic [7:0] verify_data, table_data;
  logic [31:0] prdata, rd;
  wire logic lock_bit_one = lock_bits[0];
  wire logic lock_bit_two = lock_bits[1];
  wire logic lock_bit_three = lock_bits[2];
  int bad_count = 0;
  int n_compared = 0;
  cml_lock_ctrl uut (.*);
  cml_prog_model prog (.*);
  always #4 mclk = ~mclk;
  // ----
  // Shared tasks
  // ----
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 20)
    begin
      n++;
      @(posedge mclk);
    end
    if (n == 20)
    begin
      bad_count++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst();
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
  endtask
  // Request from the programmer and the core together; leaves at the answer
  task automatic fire(input logic [13:0] a);
    @(posedge mclk);
    addr <= a;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    ext_fetch_req <= 1'b1;
    code_table_read_instruction <= 1'b1;
    fetch_from_external <= 1'b1;
    @(posedge mclk);
    ext_fetch_req <= 1'b0;
    code_table_read_instruction <= 1'b0;
    fetch_from_external <= 1'b0;
    #1;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    chk("rst_grant", prog_grant, 1'b0);
    foreach (rows[i])
    begin
      @(posedge mclk);
      level <= rows[i].lvl;
      scramble_programmed <= rows[i].scr;
      rst();
      apb(1'b0, CML_OFF_LOCK_STATUS, 32'h0);
      chk("status", rd, {20'h0, rows[i].st});
      fire(14'h0100);
      chk("v_valid", verify_valid, rows[i].vv);
      chk("v_refused", verify_refused, !rows[i].vv);
      chk("v_data", verify_data, rows[i].vd);
      chk("p_grant", prog_grant, rows[i].pg);
      chk("p_refused", prog_refused, !rows[i].pg);
      chk("t_data", table_data, rows[i].tb);
      chk("t_refused", table_refused, rows[i].lvl != 3'h0);
      chk("exec", ext_fetch_allow, rows[i].ex);
      apb(1'b0, CML_OFF_VIOLATION, 32'h0);
      chk("vio", rd, {27'h0, rows[i].vio});
      apb(1'b1, CML_OFF_VIOLATION, 32'h1F);
      apb(1'b0, CML_OFF_VIOLATION, 32'h0);
      // An undefined pattern raises its flag every cycle, so the clear cannot win
      chk("vio_clr", rd, {27'h0, rows[i].lvl == 3'h4, 4'h0});
      external_access_select <= 1'b0;
      repeat (5) @(posedge mclk);
      chk("code_sel", internal_code_select, rows[i].isel);
      external_access_select <= 1'b1;
    end
    level <= 3'h3;
    rst();
    foreach (sig_a[k])
    begin
      fire(sig_a[k]);
      chk("sig", verify_data, sig_v[k]);
    end
    apb(1'b0, CML_OFF_SIG_MAKER, 32'h0);
    chk("sig_reg", rd, {24'h0, CML_SIG_MAKER_DEF});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", er, 1'b1);
    apb(1'b1, CML_OFF_LOCK_STATUS, 32'hFFFF_FFFF);
    chk("ro_write", er, 1'b1);
    // Requests before capture are refused even when unlocked
    level <= 3'h0;
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    fire(14'h0200);
    chk("early_verify", verify_refused, 1'b1);
    chk("early_prog", prog_refused, 1'b1);
    @(posedge mclk);
    rst();
    level <= 3'h3;
    fire(14'h0200);
    chk("late_lock", prog_grant, 1'b1);
    tally_and_finish();
  end
endmodule
